// File: rtl/fltm_issue_timing.sv
// Issue and occupancy timing of the FP unit and load/store unit
`include "fltm_regs.svh"
module fltm_issue_timing
    import fltm_pkg::*;
#(
    parameter int NW = 6
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fp_issue,
    input wire fltm_fp_op_e fp_op,
    output logic fp_avail,
    output logic fp_done,
    output logic fp_exec_ser,
    input wire logic ls_issue,
    input wire fltm_ls_op_e ls_op,
    input wire logic ls_global,
    input wire logic [4:0] ls_nwords,
    output logic ls_avail,
    output logic ls_done,
    output logic ls_exec_ser,
    output logic ls_cmpl_ser,
    input wire logic cmpl_retire,
    output logic cq_full
);
    // ************************************************************
    // Completion queue occupancy
    // ************************************************************
    logic [2:0] inflight_r;
    logic fp_take;
    logic ls_take;
    logic [2:0] n_issue;
    logic cq_last;

    assign cq_full = (inflight_r >= `FLTM_MAX_INFLIGHT);
    assign cq_last = (inflight_r == `FLTM_MAX_INFLIGHT - 3'h1);
    assign fp_take = fp_issue && fp_avail;
    assign ls_take = ls_issue && ls_avail;
    assign n_issue = {2'b00, fp_take} + {2'b00, ls_take};

    // Room check counts a same-cycle pair, so six is never passed
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            inflight_r <= 3'h0;
        else
            inflight_r <= inflight_r + n_issue
                - {2'b00, cmpl_retire && inflight_r != 3'h0};
    end

    // ************************************************************
    // Floating-point unit
    // ************************************************************
    fltm_fst_e fst_r;
    logic [5:0] fbusy_r;
    logic [1:0] ftail_r;
    logic fser_r;
    logic fp_ser_op;
    logic ls_hold;

    assign fp_ser_op = (fp_op == FLTM_FP_FSRD);
    // Accept only when idle or a pipeline slot frees this cycle
    assign fp_avail = !cq_full && !fser_r && !ls_hold
        && (fst_r == FLTM_FS_IDLE || fst_r == FLTM_FS_TAIL);
    assign fp_exec_ser = fser_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fst_r <= FLTM_FS_IDLE;
            fbusy_r <= 6'h00;
        end
        else if (fp_take)
        begin
            case (fp_op)
                FLTM_FP_SDIV:
                begin
                    fst_r <= FLTM_FS_BUSY;
                    fbusy_r <= `FLTM_SDIV_CYC - 6'h01;
                end
                FLTM_FP_DDIV:
                begin
                    fst_r <= FLTM_FS_BUSY;
                    fbusy_r <= `FLTM_DDIV_CYC - 6'h01;
                end
                FLTM_FP_FSCR:
                begin
                    fst_r <= FLTM_FS_BUSY;
                    fbusy_r <= `FLTM_FSCR_CYC - 6'h01;
                end
                FLTM_FP_P211:
                begin
                    fst_r <= FLTM_FS_ST1;
                    fbusy_r <= 6'h00;
                end
                default:
                begin
                    fst_r <= FLTM_FS_TAIL;
                    fbusy_r <= 6'h00;
                end
            endcase
        end
        else
        begin
            case (fst_r)
                FLTM_FS_ST1:
                    fst_r <= FLTM_FS_TAIL;
                FLTM_FS_BUSY:
                begin
                    if (fbusy_r == 6'h01)
                        fst_r <= FLTM_FS_IDLE;
                    fbusy_r <= fbusy_r - 6'h01;
                end
                FLTM_FS_TAIL:
                    fst_r <= FLTM_FS_IDLE;
                default:
                    fst_r <= FLTM_FS_IDLE;
            endcase
        end
    end

    // Two remaining stages after stage one; non-pipelined ops end in busy
    logic [1:0] fpipe_r;
    logic fdiv_end_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fpipe_r <= 2'h0;
        else
            fpipe_r <= {fpipe_r[0], fst_r == FLTM_FS_TAIL};
    end

    // Finish lands in the cycle the unit is free again, as for issue
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fdiv_end_r <= 1'b0;
        else
            fdiv_end_r <= (fst_r == FLTM_FS_BUSY)
                && (fbusy_r == 6'h01);
    end

    // Stage two enters when the op leaves stage one (TAIL state)
    assign fp_done = fpipe_r[1] || fdiv_end_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ftail_r <= 2'h0;
        else if (fp_take && fp_ser_op)
            ftail_r <= 2'h2;
        else if (ftail_r != 2'h0)
            ftail_r <= ftail_r - 2'h1;
    end

    // Serialized FP ops hold further issue until they finish
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fser_r <= 1'b0;
        else if (fp_take && fp_ser_op)
            fser_r <= 1'b1;
        else if (fser_r && ftail_r == 2'h1)
            fser_r <= 1'b0;
    end

    // ************************************************************
    // Load/store unit
    // ************************************************************
    logic [5:0] lat_cnt;
    logic [5:0] thr_cnt;
    logic ls_ser_op;
    logic ls_cser_op;
    logic lat_done;
    logic plain_take;
    logic [1:0] lpipe_r;
    logic thr_active;
    logic lser_r;
    logic lcser_r;
    logic [5:0] mult_cyc;

    assign mult_cyc = `FLTM_MULT_BASE + {1'b0, ls_nwords};

    // Latency and throughput lookup
    always_comb
    begin
        lat_cnt = `FLTM_LS_LAT;
        thr_cnt = `FLTM_LS_THR;
        ls_ser_op = 1'b1;
        ls_cser_op = 1'b0;
        if (ls_op == FLTM_LS_PLAIN)
            ls_ser_op = 1'b0;
        else if (ls_op == FLTM_LS_FLUSH)
        begin
            lat_cnt = `FLTM_FLUSH_LAT;
            thr_cnt = `FLTM_FLUSH_THR;
        end
        else if (ls_op == FLTM_LS_DINV)
        begin
            lat_cnt = `FLTM_DINV_LAT;
            thr_cnt = `FLTM_DINV_THR;
        end
        else if (ls_op == FLTM_LS_IINV)
        begin
            lat_cnt = `FLTM_IINV_LAT;
            thr_cnt = `FLTM_IINV_THR;
        end
        else if (ls_op == FLTM_LS_ZERO)
        begin
            lat_cnt = `FLTM_ZERO_LAT;
            thr_cnt = ls_global ? `FLTM_ZERO_GTHR : `FLTM_ZERO_THR;
        end
        else if (ls_op == FLTM_LS_LDMUL)
        begin
            lat_cnt = mult_cyc;
            thr_cnt = mult_cyc;
            ls_cser_op = 1'b1;
        end
        else if (ls_op == FLTM_LS_STMUL)
        begin
            lat_cnt = mult_cyc;
            thr_cnt = mult_cyc;
        end
        else
        begin
            lat_cnt = `FLTM_RSV_LAT;
            thr_cnt = `FLTM_RSV_THR;
        end
    end

    // Conditional store shares the reserve class with 8:8 when nwords=31
    logic cst_op;
    logic [5:0] lat_use;
    logic [5:0] thr_use;
    assign cst_op = (ls_op == FLTM_LS_RSV) && (ls_nwords == 5'h1F);
    assign lat_use = cst_op ? `FLTM_CST_LAT : lat_cnt;
    assign thr_use = cst_op ? `FLTM_CST_THR : thr_cnt;

    // Throughput counter gates availability; latency counter finishes
    fltm_delay #(.W(6)) u_thr (
        .clk(clk),
        .rst_b(rst_b),
        .load(ls_take),
        .count(thr_use - 6'h01),
        .done(),
        .active(thr_active)
    );

    // Only serialized classes use the counter; plain ops may overlap
    assign plain_take = ls_take && (ls_op == FLTM_LS_PLAIN);

    fltm_delay #(.W(6)) u_lat (
        .clk(clk),
        .rst_b(rst_b),
        .load(ls_take && !plain_take),
        .count(lat_use),
        .done(lat_done),
        .active()
    );

    // Plain latency is fixed, so a two-slot pipe tracks each in flight
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            lpipe_r <= 2'h0;
        else
            lpipe_r <= {lpipe_r[0], plain_take};
    end

    assign ls_done = lpipe_r[1] || lat_done;
    // Serial hold lifts in the finishing cycle, so throughput stays exact
    assign ls_hold = lser_r && !lat_done;
    // Second issue in one cycle must not push the queue past six
    assign ls_avail = !cq_full && !thr_active && !ls_hold && !fser_r
        && !(cq_last && fp_take);

    // Serialized LS ops block all issue until they finish
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lser_r <= 1'b0;
            lcser_r <= 1'b0;
        end
        else if (ls_take)
        begin
            lser_r <= ls_ser_op;
            lcser_r <= ls_cser_op;
        end
        else if (lat_done)
        begin
            lser_r <= 1'b0;
            lcser_r <= 1'b0;
        end
    end

    assign ls_exec_ser = lser_r;
    assign ls_cmpl_ser = lcser_r;

    // ************************************************************
    // Checks
    // ************************************************************
    sdiv_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
        fp_take && fp_op == FLTM_FP_SDIV |-> ##1 !fp_avail [*8]
        ##1 !fp_avail [*8] ##1 fp_done) else $error("sdiv occupancy wrong");
    ddiv_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        fp_take && fp_op == FLTM_FP_DDIV |-> ##31 fp_done)
        else $error("ddiv finish wrong");
    fscr_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
        fp_take && fp_op == FLTM_FP_FSCR |-> ##1 !fp_avail ##1 !fp_avail
        ##1 fp_done) else $error("status write timing wrong");
    p211_avail_a: assert property (@(posedge clk) disable iff (!rst_b)
        fp_take && fp_op == FLTM_FP_P211 |-> ##1 !fp_avail)
        else $error("2-1-1 stage one not held");
    plain_lat_a: assert property (@(posedge clk) disable iff (!rst_b)
        ls_take && ls_op == FLTM_LS_PLAIN |-> ##2 ls_done)
        else $error("plain load latency wrong");
    flush_thr_a: assert property (@(posedge clk) disable iff (!rst_b)
        ls_take && ls_op == FLTM_LS_FLUSH |-> ##1 !ls_avail [*4])
        else $error("flush throughput wrong");
    gzero_thr_a: assert property (@(posedge clk) disable iff (!rst_b)
        ls_take && ls_op == FLTM_LS_ZERO && ls_global
        |-> ##1 !ls_avail [*8] ##1 !ls_avail ##1 !ls_avail)
        else $error("global zero throughput short");
    ldmul_ser_a: assert property (@(posedge clk) disable iff (!rst_b)
        ls_take && ls_op == FLTM_LS_LDMUL |-> ##1 ls_cmpl_ser && ls_exec_ser)
        else $error("load multiple not serialized");
    cq_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
        inflight_r <= `FLTM_MAX_INFLIGHT)
        else $error("too many in flight");
endmodule

// File: shared/fltm_regs.svh
// Timing constants for the FP and load/store issue timing block
`ifndef FLTM_REGS_SVH
`define FLTM_REGS_SVH
`define FLTM_SDIV_CYC 6'h11
`define FLTM_DDIV_CYC 6'h1F
`define FLTM_FSCR_CYC 6'h03
`define FLTM_LS_LAT 6'h02
`define FLTM_LS_THR 6'h01
`define FLTM_FLUSH_LAT 6'h03
`define FLTM_FLUSH_THR 6'h05
`define FLTM_DINV_LAT 6'h03
`define FLTM_DINV_THR 6'h03
`define FLTM_IINV_LAT 6'h03
`define FLTM_IINV_THR 6'h04
`define FLTM_ZERO_LAT 6'h03
`define FLTM_ZERO_THR 6'h06
`define FLTM_ZERO_GTHR 6'h0B
`define FLTM_MULT_BASE 6'h02
`define FLTM_RSV_LAT 6'h03
`define FLTM_RSV_THR 6'h01
`define FLTM_CST_LAT 6'h08
`define FLTM_CST_THR 6'h08
`define FLTM_MAX_INFLIGHT 3'h6
`endif

// File: shared/fltm_pkg.sv
// Types for the FP and load/store issue timing block
package fltm_pkg;
    // FP operation classes
    typedef enum logic [2:0] {
        FLTM_FP_P111 = 3'h0,
        FLTM_FP_P211 = 3'h1,
        FLTM_FP_SDIV = 3'h2,
        FLTM_FP_DDIV = 3'h3,
        FLTM_FP_FSCR = 3'h4,
        FLTM_FP_FSRD = 3'h5
    } fltm_fp_op_e;
    // Load/store operation classes
    typedef enum logic [2:0] {
        FLTM_LS_PLAIN = 3'h0,
        FLTM_LS_FLUSH = 3'h1,
        FLTM_LS_DINV = 3'h2,
        FLTM_LS_IINV = 3'h3,
        FLTM_LS_ZERO = 3'h4,
        FLTM_LS_LDMUL = 3'h5,
        FLTM_LS_STMUL = 3'h6,
        FLTM_LS_RSV = 3'h7
    } fltm_ls_op_e;
    typedef enum logic [3:0] {
        FLTM_FS_IDLE = 4'h1,
        FLTM_FS_ST1 = 4'h2,
        FLTM_FS_BUSY = 4'h4,
        FLTM_FS_TAIL = 4'h8
    } fltm_fst_e;
endpackage

// File: rtl/fltm_delay.sv
// Countdown timer that pulses when a loaded count expires
module fltm_delay
    import fltm_pkg::*;
#(
    parameter int W = 6
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done,
    output logic active
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= '0;
        else if (load)
            cnt_r <= count;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end

    // A reload in the final cycle must not swallow the old op's finish
    assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    assign active = (cnt_r != '0);
endmodule

// File: bench/fltm_cmpl_model.sv
// Completion-side partner that retires each finished operation
module fltm_cmpl_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fp_done,
    input wire logic ls_done,
    input wire logic hold,
    output logic cmpl_retire
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Retire queue
    // ****************************************
    logic [3:0] pend_r;
    logic [3:0] pend_nxt;

    // Hold lets finished ops pile up so the queue can fill
    always_comb
        pend_nxt = pend_r + 4'(fp_done) + 4'(ls_done) - 4'(cmpl_retire);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_r <= 4'h0;
            cmpl_retire <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            cmpl_retire <= (pend_nxt != 4'h0) && !hold;
        end
    end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the FP and load/store issue timing block
module tb_top
    import fltm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk, rst_b, fp_issue, fp_avail, fp_done, fp_exec_ser;
    logic ls_issue, ls_global, ls_avail, ls_done, ls_exec_ser;
    logic ls_cmpl_ser, cmpl_retire, cq_full, hold;
    logic [4:0] ls_nwords;
    fltm_fp_op_e fp_op;
    fltm_ls_op_e ls_op;
    int failures;
    int total_checks;

    always #2.5 clk = ~clk;

    fltm_issue_timing dut (.clk(clk), .rst_b(rst_b), .fp_issue(fp_issue),
        .fp_op(fp_op), .fp_avail(fp_avail), .fp_done(fp_done),
        .fp_exec_ser(fp_exec_ser), .ls_issue(ls_issue), .ls_op(ls_op),
        .ls_global(ls_global), .ls_nwords(ls_nwords), .ls_avail(ls_avail),
        .ls_done(ls_done), .ls_exec_ser(ls_exec_ser),
        .ls_cmpl_ser(ls_cmpl_ser), .cmpl_retire(cmpl_retire),
        .cq_full(cq_full));
    fltm_cmpl_model cmpl (.clk(clk), .rst_b(rst_b), .fp_done(fp_done),
        .ls_done(ls_done), .hold(hold), .cmpl_retire(cmpl_retire));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    // Bounded wait so a stuck unit ends the run instead of hanging
    task automatic wait_av(input logic fp);
        int n;
        n = 0;
        @(negedge clk);
        while ((fp ? fp_avail : ls_avail) !== 1'b1)
        begin
            n++;
            if (n > 60)
            begin
                chk(1'b0, "unit never free");
                print_verdict;
            end
            @(negedge clk);
        end
    endtask

    // Issue one op, then measure done latency and unavailable length
    task automatic op_chk(input logic fp, input logic [2:0] op,
        input logic glb, input logic [4:0] nw, input int lat,
        input int low, input logic es, input logic cs);
        int d, l, nd;
        logic seen;
        d = 0;
        l = 0;
        nd = 0;
        seen = 1'b0;
        wait_av(fp);
        fp_op = fltm_fp_op_e'(op);
        ls_op = fltm_ls_op_e'(op);
        ls_global = glb;
        ls_nwords = nw;
        fp_issue = fp;
        ls_issue = !fp;
        for (int k = 1; k < 40; k++)
        begin
            @(negedge clk);
            fp_issue = 1'b0;
            ls_issue = 1'b0;
            if (k == 1)
            begin
                chk((fp ? fp_exec_ser : ls_exec_ser) === es, "exec serial");
                chk(fp || ls_cmpl_ser === cs, "completion serial");
                chk(!es || (fp ? ls_avail : fp_avail) === 1'b0, "other unit");
            end
            if ((fp ? fp_done : ls_done) === 1'b1)
            begin
                nd++;
                if (d == 0)
                    d = k;
            end
            if ((fp ? fp_avail : ls_avail) === 1'b1)
                seen = 1'b1;
            else if (!seen)
                l++;
        end
        chk(d == lat && nd == 1, "done timing");
        chk(l == low, "busy length");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_fp;
        op_chk(1, FLTM_FP_P111, 0, 0, 3, 0, 0, 0);
        op_chk(1, FLTM_FP_P211, 0, 0, 4, 1, 0, 0);
        op_chk(1, FLTM_FP_FSRD, 0, 0, 3, 2, 1, 0);
        op_chk(1, FLTM_FP_SDIV, 0, 0, 17, 16, 0, 0);
        op_chk(1, FLTM_FP_DDIV, 0, 0, 31, 30, 0, 0);
        op_chk(1, FLTM_FP_FSCR, 0, 0, 3, 2, 0, 0);
        $display("test fp classes done");
    endtask

    task automatic t_ls;
        op_chk(0, FLTM_LS_PLAIN, 0, 0, 2, 0, 0, 0);
        op_chk(0, FLTM_LS_FLUSH, 0, 0, 3, 4, 1, 0);
        op_chk(0, FLTM_LS_DINV, 0, 0, 3, 2, 1, 0);
        op_chk(0, FLTM_LS_IINV, 0, 0, 3, 3, 1, 0);
        op_chk(0, FLTM_LS_ZERO, 0, 0, 3, 5, 1, 0);
        op_chk(0, FLTM_LS_ZERO, 1, 0, 3, 10, 1, 0);
        op_chk(0, FLTM_LS_RSV, 0, 0, 3, 2, 1, 0);
        op_chk(0, FLTM_LS_RSV, 0, 5'h1F, 8, 7, 1, 0);
        op_chk(0, FLTM_LS_LDMUL, 0, 5'h04, 6, 5, 1, 1);
        op_chk(0, FLTM_LS_LDMUL, 0, 5'h00, 2, 1, 1, 1);
        op_chk(0, FLTM_LS_STMUL, 0, 5'h01, 3, 2, 1, 0);
        $display("test load store classes done");
    endtask

    // Second op held on the port while a divide runs must wait
    task automatic t_refuse;
        int d1, d2;
        logic tk;
        d1 = 0;
        d2 = 0;
        tk = 1'b0;
        wait_av(1);
        fp_op = FLTM_FP_SDIV;
        fp_issue = 1'b1;
        for (int k = 1; k < 30; k++)
        begin
            @(negedge clk);
            fp_op = FLTM_FP_P111;
            if (tk)
                fp_issue = 1'b0;
            tk = k > 1 && fp_avail === 1'b1;
            if (fp_done === 1'b1)
            begin
                d2 = d1 ? k : 0;
                d1 = d1 ? d1 : k;
            end
        end
        chk(d1 == 17 && d2 == 20, "held issue while busy");
        $display("test busy refusal done");
    endtask

    // Retirement held back: only six ops may be taken
    task automatic t_cq;
        int n, f, l;
        n = 0;
        f = 0;
        l = 0;
        hold = 1'b1;
        wait_av(0);
        ls_op = FLTM_LS_PLAIN;
        ls_issue = 1'b1;
        for (int k = 1; k < 15; k++)
        begin
            @(negedge clk);
            if (k == 9)
                ls_issue = 1'b0;
            if (ls_done === 1'b1)
            begin
                n++;
                f = f ? f : k;
                l = k;
            end
        end
        chk(n == 6 && f == 2 && l == 7, "back to back count");
        chk(cq_full === 1'b1 && ls_avail === 1'b0, "queue full");
        hold = 1'b0;
        n = 0;
        while (cq_full !== 1'b0 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        chk(cq_full === 1'b0, "queue drains");
        $display("test completion queue done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        fp_issue = 1'b0;
        fp_op = FLTM_FP_P111;
        ls_issue = 1'b0;
        ls_op = FLTM_LS_PLAIN;
        ls_global = 1'b0;
        ls_nwords = 5'h00;
        hold = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        t_fp;
        t_ls;
        t_refuse;
        t_cq;
        print_verdict;
    end
endmodule
